// *** core/port_xbar_defs.vh ***
/*
 * port_xbar_defs.vh - register offsets, field positions, reset values
 * and crossbar signal indices for the port crossbar and gpio block.
 * assumes: included by bare name from the design file; definitions only.
 */
`ifndef PORT_XBAR_DEFS_VH
`define PORT_XBAR_DEFS_VH

// ****************
// register byte offsets
// ****************
`define ADDR_PORT0_LATCH       8'h80
`define ADDR_PORT1_LATCH       8'h90
`define ADDR_PORT0_OUTPUT_MODE 8'hA4
`define ADDR_PORT1_OUTPUT_MODE 8'hA5
`define ADDR_PORT0_SKIP        8'hD4
`define ADDR_PORT1_SKIP        8'hD5
`define ADDR_ROUTE_A           8'hE1
`define ADDR_ROUTE_B           8'hE2
`define ADDR_PORT0_INPUT_MODE  8'hF1
`define ADDR_PORT1_INPUT_MODE  8'hF2
`define ADDR_ROUTE_C           8'hF3

// ****************
// reset values
// ****************
`define RST_LATCH     8'hFF
`define RST_IN_MODE   8'hFF
`define RST_OUT_MODE  8'h00
`define RST_SKIP      8'h00
`define RST_ROUTE     8'h00

// ****************
// field positions
// ****************
`define A_CMP1_ASYNC  7
`define A_CMP1        6
`define A_CMP0_ASYNC  5
`define A_CMP0        4
`define A_SYSCLK      3
`define A_TWOWIRE     2
`define A_SPI         1
`define A_SERIAL_A    0
`define B_PULLUP_DIS  7
`define B_XBAR_EN     6
`define B_TIMER_B     5
`define B_TIMER_A     4
`define B_COUNT_IN    3
`define B_MOD_HI      2
`define C_SERIAL_B    0
`define MOD_CODE_MAX  3'h5

// ****************
// crossbar signal indices, in priority order
// ****************
`define SIG_SA_TX     0
`define SIG_SA_RX     1
`define SIG_SPI_SCK   2
`define SIG_SPI_MISO  3
`define SIG_SPI_MOSI  4
`define SIG_SPI_NSS   5
`define SIG_TW_SDA    6
`define SIG_TW_SCL    7
`define SIG_CMP0      8
`define SIG_CMP0_ASY  9
`define SIG_CMP1      10
`define SIG_CMP1_ASY  11
`define SIG_SYSCLK    12
`define SIG_MOD0      13
`define SIG_COUNT_IN  18
`define SIG_TIMER_A   19
`define SIG_TIMER_B   20
`define SIG_SB_TX     21
`define SIG_SB_RX     22
`define NSIG          23
`define NPIN          16
`define PIN_SA_TX     4
`define PIN_SA_RX     5

`endif

// *** core/port_crossbar_and_gpio.v ***
/*
 * port_crossbar_and_gpio - priority crossbar that routes peripheral
 * signals onto the sixteen pins of port 0 and port 1, plus the port
 * latch, input mode, output mode and skip registers behind an 8-bit
 * special function register port with byte and bit access.
 * assumes: one clock mclk, pins arrive asynchronously, the board
 * resolves each pin from pin_out / pin_oe / pin_pullup.
 */
// Behaviour
// - comparator route bits place comparator outputs
// - sysclock bit puts clock on a pin
// - two-wire bit routes data and clock pins
// - serial peripheral bit routes its signals
// - serial port a fixed on pins 4/5
// - pullups on unless disabled, analog, push-pull or driving low
// - crossbar off: no routing, drivers off
// - timer input bits route timer inputs
// - count input bit routes count input
// - module field routes first N module ios
// - route_c bit0 routes serial port b
// - latch write holds output data
// - plain read returns live pin levels
// - read-modify-write reads latch, not pins
// - ports accept byte and bit access
// - low drives low, high hi-z if open-drain
// - analog pin reads zero
// - input mode zero makes pin analog
// - output mode one push-pull, zero open-drain
// - two-wire pins always open-drain
// - skip bit makes crossbar pass pin
// - fixed priority, lowest free unskipped pin
// - paired peripherals claim both pins
`include "port_xbar_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module port_crossbar_and_gpio #(
    parameter NPIN = `NPIN,               // port 0 and port 1 pins
    parameter NSIG = `NSIG                // crossbar signals
) (
    input  wire            mclk,
    input  wire            rst_b,
    input  wire [7:0]      sfr_addr,
    input  wire            sfr_wr,
    input  wire [7:0]      sfr_wdata,
    input  wire            sfr_rd,
    input  wire            sfr_rmw,
    output reg  [7:0]      sfr_rdata,
    input  wire [7:0]      sfr_bit_addr,
    input  wire            sfr_bit_wr,
    input  wire            sfr_bit_wdata,
    input  wire            sfr_bit_rd,
    output reg             sfr_bit_rdata,
    input  wire            spi_nss_route,
    input  wire [NSIG-1:0] periph_out,
    input  wire [NSIG-1:0] periph_oe,
    output reg  [NSIG-1:0] periph_in,
    input  wire [NPIN-1:0] pin_in,
    output reg  [NPIN-1:0] pin_out,
    output reg  [NPIN-1:0] pin_oe,
    output reg  [NPIN-1:0] pin_pullup
);

    // ****************
    // reset release
    // ****************
    reg        rst_meta_b;                // release stage one
    reg        rst_sync_b;                // reset copy used everywhere

    // assert at once, release after two edges
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end

    // ****************
    // registers
    // ****************
    reg [7:0]  port0_latch;               // output data port 0
    reg [7:0]  port1_latch;               // output data port 1
    reg [7:0]  port0_input_mode;          // 1 digital, 0 analog
    reg [7:0]  port1_input_mode;
    reg [7:0]  port0_output_mode;         // 1 push-pull
    reg [7:0]  port1_output_mode;
    reg [7:0]  port0_crossbar_skip;       // 1 skipped
    reg [7:0]  port1_crossbar_skip;
    reg [7:0]  crossbar_route_a;
    reg [7:0]  crossbar_route_b;
    reg        serial_port_b_route_en;    // only live bit of route_c

    wire [NPIN-1:0] latch_all = {port1_latch, port0_latch};
    wire [NPIN-1:0] digital   = {port1_input_mode, port0_input_mode};
    wire [NPIN-1:0] push_mode = {port1_output_mode, port0_output_mode};
    wire [NPIN-1:0] skip_all  = {port1_crossbar_skip, port0_crossbar_skip};

    // bit address decode: port 0 and port 1 byte address plus bit
    wire       bit_p0  = (sfr_bit_addr[7:3] == `ADDR_PORT0_LATCH >> 3);
    wire       bit_p1  = (sfr_bit_addr[7:3] == `ADDR_PORT1_LATCH >> 3);
    wire [2:0] bit_sel = sfr_bit_addr[2:0];

    // ****************
    // register writes
    // ****************
    // byte writes and single-bit writes share the latches
    always @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            port0_latch            <= `RST_LATCH;
            port1_latch            <= `RST_LATCH;
            port0_input_mode       <= `RST_IN_MODE;
            port1_input_mode       <= `RST_IN_MODE;
            port0_output_mode      <= `RST_OUT_MODE;
            port1_output_mode      <= `RST_OUT_MODE;
            port0_crossbar_skip    <= `RST_SKIP;
            port1_crossbar_skip    <= `RST_SKIP;
            crossbar_route_a       <= `RST_ROUTE;
            crossbar_route_b       <= `RST_ROUTE;
            serial_port_b_route_en <= 1'b0;
        end else begin
            if (sfr_wr) begin
                case (sfr_addr)
                    `ADDR_PORT0_LATCH:       port0_latch <= sfr_wdata;
                    `ADDR_PORT1_LATCH:       port1_latch <= sfr_wdata;
                    `ADDR_PORT0_INPUT_MODE:  port0_input_mode <= sfr_wdata;
                    `ADDR_PORT1_INPUT_MODE:  port1_input_mode <= sfr_wdata;
                    `ADDR_PORT0_OUTPUT_MODE: port0_output_mode <= sfr_wdata;
                    `ADDR_PORT1_OUTPUT_MODE: port1_output_mode <= sfr_wdata;
                    `ADDR_PORT0_SKIP:        port0_crossbar_skip <= sfr_wdata;
                    `ADDR_PORT1_SKIP:        port1_crossbar_skip <= sfr_wdata;
                    `ADDR_ROUTE_A:           crossbar_route_a <= sfr_wdata;
                    `ADDR_ROUTE_B:           crossbar_route_b <= sfr_wdata;
                    // upper bits dropped; software keeps them zero
                    `ADDR_ROUTE_C:
                        serial_port_b_route_en <= sfr_wdata[`C_SERIAL_B];
                    default: ;                // unmapped: ignored
                endcase
            end
            // bit writes on the latches, after any byte write
            if (sfr_bit_wr && bit_p0) begin
                port0_latch[bit_sel] <= sfr_bit_wdata;
            end
            if (sfr_bit_wr && bit_p1) begin
                port1_latch[bit_sel] <= sfr_bit_wdata;
            end
        end
    end

    // ****************
    // pin input synchronisers
    // ****************
    reg [NPIN-1:0] pin_s1;                // first stage, read by s2 only
    reg [NPIN-1:0] pin_s2;
    reg [NPIN-1:0] pin_s3;
    reg [NPIN-1:0] pin_filt;              // accepted pin level
    integer        k;

    // a bit is accepted once stages two and three agree
    always @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            pin_s1   <= {NPIN{1'b1}};
            pin_s2   <= {NPIN{1'b1}};
            pin_s3   <= {NPIN{1'b1}};
            pin_filt <= {NPIN{1'b1}};
        end else begin
            pin_s1 <= pin_in;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            for (k = 0; k < NPIN; k = k + 1) begin
                if (pin_s2[k] == pin_s3[k]) begin
                    pin_filt[k] <= pin_s3[k];
                end
            end
        end
    end

    // analog pins have no receiver and read as zero
    wire [NPIN-1:0] pin_level = pin_filt & digital;

    // ****************
    // register reads
    // ****************
    // one-cycle latency; plain reads see pins, rmw reads see latch
    always @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            sfr_rdata     <= 8'h00;
            sfr_bit_rdata <= 1'b0;
        end else begin
            if (sfr_rd) begin
                case (sfr_addr)
                    `ADDR_PORT0_LATCH:
                        sfr_rdata <= sfr_rmw ? port0_latch
                                             : pin_level[7:0];
                    `ADDR_PORT1_LATCH:
                        sfr_rdata <= sfr_rmw ? port1_latch
                                             : pin_level[15:8];
                    `ADDR_PORT0_INPUT_MODE:  sfr_rdata <= port0_input_mode;
                    `ADDR_PORT1_INPUT_MODE:  sfr_rdata <= port1_input_mode;
                    `ADDR_PORT0_OUTPUT_MODE: sfr_rdata <= port0_output_mode;
                    `ADDR_PORT1_OUTPUT_MODE: sfr_rdata <= port1_output_mode;
                    `ADDR_PORT0_SKIP:        sfr_rdata <= port0_crossbar_skip;
                    `ADDR_PORT1_SKIP:        sfr_rdata <= port1_crossbar_skip;
                    `ADDR_ROUTE_A:           sfr_rdata <= crossbar_route_a;
                    `ADDR_ROUTE_B:           sfr_rdata <= crossbar_route_b;
                    `ADDR_ROUTE_C:
                        sfr_rdata <= {7'h00, serial_port_b_route_en};
                    default:                 sfr_rdata <= 8'h00;
                endcase
            end
            if (sfr_bit_rd) begin
                if (bit_p0) begin
                    sfr_bit_rdata <= sfr_rmw ? port0_latch[bit_sel]
                                             : pin_level[bit_sel];
                end else if (bit_p1) begin
                    sfr_bit_rdata <= sfr_rmw ? port1_latch[bit_sel]
                                             : pin_level[{1'b1, bit_sel}];
                end else begin
                    sfr_bit_rdata <= 1'b0;    // not a port bit
                end
            end
        end
    end

    // ****************
    // routing requests
    // ****************
    wire       xbar_on  = crossbar_route_b[`B_XBAR_EN];
    wire [2:0] mod_code = crossbar_route_b[`B_MOD_HI:0];
    // reserved codes fall back to no modules
    wire [2:0] mod_cnt  = (mod_code <= `MOD_CODE_MAX) ? mod_code
                                                      : 3'h0;
    reg  [NSIG-1:0] sig_en;               // signals asking for a pin
    integer         m;

    always @* begin
        sig_en = {NSIG{1'b0}};
        sig_en[`SIG_SA_TX]    = crossbar_route_a[`A_SERIAL_A];
        sig_en[`SIG_SA_RX]    = crossbar_route_a[`A_SERIAL_A];
        sig_en[`SIG_SPI_SCK]  = crossbar_route_a[`A_SPI];
        sig_en[`SIG_SPI_MISO] = crossbar_route_a[`A_SPI];
        sig_en[`SIG_SPI_MOSI] = crossbar_route_a[`A_SPI];
        // three-wire mode leaves select unrouted
        sig_en[`SIG_SPI_NSS]  = crossbar_route_a[`A_SPI] & spi_nss_route;
        sig_en[`SIG_TW_SDA]   = crossbar_route_a[`A_TWOWIRE];
        sig_en[`SIG_TW_SCL]   = crossbar_route_a[`A_TWOWIRE];
        sig_en[`SIG_CMP0]     = crossbar_route_a[`A_CMP0];
        sig_en[`SIG_CMP0_ASY] = crossbar_route_a[`A_CMP0_ASYNC];
        sig_en[`SIG_CMP1]     = crossbar_route_a[`A_CMP1];
        sig_en[`SIG_CMP1_ASY] = crossbar_route_a[`A_CMP1_ASYNC];
        sig_en[`SIG_SYSCLK]   = crossbar_route_a[`A_SYSCLK];
        for (m = 0; m < 5; m = m + 1) begin
            sig_en[`SIG_MOD0 + m] = (m < mod_cnt);
        end
        sig_en[`SIG_COUNT_IN] = crossbar_route_b[`B_COUNT_IN];
        sig_en[`SIG_TIMER_A]  = crossbar_route_b[`B_TIMER_A];
        sig_en[`SIG_TIMER_B]  = crossbar_route_b[`B_TIMER_B];
        sig_en[`SIG_SB_TX]    = serial_port_b_route_en;
        sig_en[`SIG_SB_RX]    = serial_port_b_route_en;
        if (!xbar_on) begin
            sig_en = {NSIG{1'b0}};
        end
    end

    // ****************
    // priority allocation
    // ****************
    reg [4:0]      pin_sig [0:NPIN-1];    // signal on pin, if pin_hit
    reg [NPIN-1:0] pin_hit;
    reg [3:0]      sig_pin [0:NSIG-1];    // pin of signal, if sig_hit
    reg [NSIG-1:0] sig_hit;
    reg [NPIN-1:0] taken;
    reg            found;
    reg [NPIN-1:0] tw_pins;               // pins carrying two-wire
    integer        s;
    integer        p;

    // pairs are requested together; a pair with one free pin
    // is dropped whole so no half-routed pair appears
    always @* begin
        taken   = skip_all;
        pin_hit = {NPIN{1'b0}};
        sig_hit = {NSIG{1'b0}};
        found   = 1'b0;
        for (p = 0; p < NPIN; p = p + 1) begin
            pin_sig[p] = 5'h00;
        end
        for (s = 0; s < NSIG; s = s + 1) begin
            sig_pin[s] = 4'h0;
        end
        // serial port a ignores skip and priority
        if (sig_en[`SIG_SA_TX]) begin
            taken[`PIN_SA_TX]   = 1'b1;
            taken[`PIN_SA_RX]   = 1'b1;
            pin_hit[`PIN_SA_TX] = 1'b1;
            pin_hit[`PIN_SA_RX] = 1'b1;
            pin_sig[`PIN_SA_TX] = 5'd`SIG_SA_TX;
            pin_sig[`PIN_SA_RX] = 5'd`SIG_SA_RX;
            sig_hit[`SIG_SA_TX] = 1'b1;
            sig_hit[`SIG_SA_RX] = 1'b1;
            sig_pin[`SIG_SA_TX] = 4'd`PIN_SA_TX;
            sig_pin[`SIG_SA_RX] = 4'd`PIN_SA_RX;
        end
        for (s = `SIG_SPI_SCK; s < NSIG; s = s + 1) begin
            found = 1'b0;
            if (sig_en[s]) begin
                for (p = 0; p < NPIN; p = p + 1) begin
                    if (!found && !taken[p]) begin
                        found      = 1'b1;
                        taken[p]   = 1'b1;
                        pin_hit[p] = 1'b1;
                        pin_sig[p] = s[4:0];
                        sig_hit[s] = 1'b1;
                        sig_pin[s] = p[3:0];
                    end
                end
            end
        end
        // drop half pairs
        if (sig_hit[`SIG_TW_SDA] != sig_hit[`SIG_TW_SCL]) begin
            pin_hit[sig_pin[`SIG_TW_SDA]] = 1'b0;
            sig_hit[`SIG_TW_SDA] = 1'b0;
        end
        if (sig_hit[`SIG_SB_TX] != sig_hit[`SIG_SB_RX]) begin
            pin_hit[sig_pin[`SIG_SB_TX]] = 1'b0;
            sig_hit[`SIG_SB_TX] = 1'b0;
        end
        tw_pins = {NPIN{1'b0}};
        for (p = 0; p < NPIN; p = p + 1) begin
            if (pin_hit[p] && (pin_sig[p] == `SIG_TW_SDA ||
                               pin_sig[p] == `SIG_TW_SCL)) begin
                tw_pins[p] = 1'b1;
            end
        end
    end

    // ****************
    // pin drivers
    // ****************
    reg [NPIN-1:0] next_out;
    reg [NPIN-1:0] next_oe;
    reg [NPIN-1:0] next_pull;
    reg            val;
    reg            pp;

    // a peripheral that releases its line acts like a latch one
    always @* begin
        next_out  = {NPIN{1'b1}};
        next_oe   = {NPIN{1'b0}};
        next_pull = {NPIN{1'b0}};
        val       = 1'b1;
        pp        = 1'b0;
        for (p = 0; p < NPIN; p = p + 1) begin
            if (pin_hit[p]) begin
                val = periph_oe[pin_sig[p]] ? periph_out[pin_sig[p]] : 1'b1;
            end else begin
                val = latch_all[p];
            end
            pp = push_mode[p] & ~tw_pins[p];
            next_out[p] = val;
            if (xbar_on && digital[p]) begin
                next_oe[p] = ~val | pp;
            end
            // pullup only on digital open-drain not driving low
            next_pull[p] = ~crossbar_route_b[`B_PULLUP_DIS] & digital[p]
                           & ~pp & ~(next_oe[p] & ~val);
        end
    end

    // registered so pins never see allocation glitches
    always @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            pin_out    <= {NPIN{1'b1}};
            pin_oe     <= {NPIN{1'b0}};
            pin_pullup <= {NPIN{1'b0}};
        end else begin
            pin_out    <= next_out;
            pin_oe     <= next_oe;
            pin_pullup <= next_pull;
        end
    end

    // ****************
    // peripheral inputs
    // ****************
    reg [NSIG-1:0] next_in;

    // unrouted inputs idle high
    always @* begin
        next_in = {NSIG{1'b1}};
        for (s = 0; s < NSIG; s = s + 1) begin
            if (sig_hit[s]) begin
                next_in[s] = pin_level[sig_pin[s]];
            end
        end
    end

    always @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            periph_in <= {NSIG{1'b1}};
        end else begin
            periph_in <= next_in;
        end
    end

endmodule

`default_nettype wire

// *** verification/port_xbar_monitor.sv ***
/* port_xbar_monitor - concurrent checks on the crossbar ports.
 * assumes: bound into the crossbar top; shadows mirror register writes. */
`timescale 1ns/1ps
`default_nettype none
// ****************
// checker
// ****************
module port_xbar_monitor #(parameter NPIN = 16) (
    input wire logic            mclk,
    input wire logic            rst_b,
    input wire logic [7:0]      sfr_addr,
    input wire logic            sfr_wr,
    input wire logic [7:0]      sfr_wdata,
    input wire logic            sfr_rd,
    input wire logic            sfr_rmw,
    input wire logic [7:0]      sfr_rdata,
    input wire logic [7:0]      sfr_bit_addr,
    input wire logic            sfr_bit_wr,
    input wire logic            sfr_bit_wdata,
    input wire logic            sfr_bit_rd,
    input wire logic            sfr_bit_rdata,
    input wire logic [NPIN-1:0] pin_out,
    input wire logic [NPIN-1:0] pin_oe,
    input wire logic [NPIN-1:0] pin_pullup
);
    logic [7:0]      sh_b;   // route_b copy
    logic [NPIN-1:0] sh_im;  // input mode copy
    logic [NPIN-1:0] sh_om;  // output mode copy
    logic [NPIN-1:0] sh_lat; // latch copy
    // mirror writes; bit write lands last so it wins
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sh_b <= 8'h00;
            sh_im <= 16'hFFFF;
            sh_om <= 16'h0000;
            sh_lat <= 16'hFFFF;
        end else begin
            if (sfr_wr && sfr_addr == 8'hE2) sh_b <= sfr_wdata;
            if (sfr_wr && sfr_addr == 8'hF1) sh_im[7:0] <= sfr_wdata;
            if (sfr_wr && sfr_addr == 8'hF2) sh_im[15:8] <= sfr_wdata;
            if (sfr_wr && sfr_addr == 8'hA4) sh_om[7:0] <= sfr_wdata;
            if (sfr_wr && sfr_addr == 8'hA5) sh_om[15:8] <= sfr_wdata;
            if (sfr_wr && sfr_addr == 8'h80) sh_lat[7:0] <= sfr_wdata;
            if (sfr_wr && sfr_addr == 8'h90) sh_lat[15:8] <= sfr_wdata;
            if (sfr_bit_wr && sfr_bit_addr[7:5] == 3'h4 && !sfr_bit_addr[3])
                sh_lat[{sfr_bit_addr[4], sfr_bit_addr[2:0]}] <= sfr_bit_wdata;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    xbar_off_a: assert property (!(sh_b[6] | $past(sh_b[6])
        | $past(sh_b[6], 2)) |-> pin_oe == '0) else $error("driver on");
    pull_dis_a: assert property (sh_b[7] && $past(sh_b[7])
        && $past(sh_b[7], 2) |-> pin_pullup == '0) else $error("pullup on");
    low_nopull_a: assert property ((pin_pullup & pin_oe & ~pin_out) == '0)
        else $error("pullup while low");
    analog_quiet_a: assert property ($stable(sh_im)
        && sh_im == $past(sh_im, 2) |-> ((pin_oe | pin_pullup) & ~sh_im) == '0)
        else $error("analog pin active");
    open_drain_a: assert property ($stable(sh_om)
        && sh_om == $past(sh_om, 2) |-> (pin_oe & pin_out & ~sh_om) == '0)
        else $error("open-drain pin driven high");
    rmw_latch_a: assert property (sfr_rd && sfr_rmw && sfr_addr == 8'h80
        |=> sfr_rdata == $past(sh_lat[7:0])) else $error("rmw read wrong");
    analog_zero_a: assert property (sfr_rd && !sfr_rmw && sfr_addr == 8'h80
        |=> (sfr_rdata & ~$past(sh_im[7:0])) == 8'h00) else $error("analog 1");
    route_read_a: assert property (sfr_rd && sfr_addr == 8'hE2
        |=> sfr_rdata == $past(sh_b)) else $error("route_b read wrong");
    bit_rmw_a: assert property (sfr_bit_rd && sfr_rmw && sfr_bit_addr == 8'h93
        |=> sfr_bit_rdata == $past(sh_lat[11])) else $error("bit read wrong");
    route_c_a: assert property (sfr_rd && sfr_addr == 8'hF3
        |=> sfr_rdata[7:1] == 7'h00) else $error("reserved bits set");
    cover property (sfr_wr && sfr_addr == 8'hE2 && sfr_wdata[6]);
    cover property (sfr_rd && sfr_rmw);
    cover property (sfr_bit_wr);
endmodule
bind port_crossbar_and_gpio port_xbar_monitor #(.NPIN(NPIN)) mon_u (
    .mclk(mclk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rmw(sfr_rmw),
    .sfr_rdata(sfr_rdata), .sfr_bit_addr(sfr_bit_addr),
    .sfr_bit_wr(sfr_bit_wr), .sfr_bit_wdata(sfr_bit_wdata),
    .sfr_bit_rd(sfr_bit_rd), .sfr_bit_rdata(sfr_bit_rdata),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup));
`default_nettype wire

// *** verification/pin_board.sv ***
/* pin_board - board side of the sixteen port pins.
 * assumes: bench forces lines through ext_en/ext_val. */
`timescale 1ns/1ps
`default_nettype none
module pin_board (
    input wire logic        mclk,
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe,
    input wire logic [15:0] pin_pullup,
    input wire logic [15:0] ext_en,
    input wire logic [15:0] ext_val,
    output var logic [15:0] pin_in
);
    logic [15:0] flt = 16'h5555; // floating lines wander each cycle
    always @(posedge mclk) flt <= ~flt;
    // external driver, then device driver, then weak pullup
    always_comb pin_in = (ext_en & ext_val) | (~ext_en & ((pin_oe & pin_out)
        | (~pin_oe & (pin_pullup | flt))));
endmodule
`default_nettype wire

// *** verification/tb.sv ***
/* tb - directed scenarios for the port crossbar and gpio block.
 * assumes: design and pin_board compiled first; inputs move on negedge. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        mclk = 0, rst_b = 0, sfr_wr = 0, sfr_rd = 0, sfr_rmw = 0;
    logic        sfr_bit_wr = 0, sfr_bit_wdata = 0, sfr_bit_rd = 0;
    logic        sfr_bit_rdata;
    logic [7:0]  sfr_addr = 0, sfr_wdata = 0, sfr_bit_addr = 0, sfr_rdata;
    logic [22:0] periph_out = '1, periph_oe = '0, periph_in;
    logic [15:0] pin_in, pin_out, pin_oe, pin_pullup, ext_en = 0, ext_val = 0;
    int          errors = 0, num_checks = 0;
    always #20 mclk = ~mclk;
    port_crossbar_and_gpio dut_u (.mclk(mclk), .rst_b(rst_b),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
        .sfr_rd(sfr_rd), .sfr_rmw(sfr_rmw), .sfr_rdata(sfr_rdata),
        .sfr_bit_addr(sfr_bit_addr), .sfr_bit_wr(sfr_bit_wr),
        .sfr_bit_wdata(sfr_bit_wdata), .sfr_bit_rd(sfr_bit_rd),
        .sfr_bit_rdata(sfr_bit_rdata), .spi_nss_route(1'b0),
        .periph_out(periph_out), .periph_oe(periph_oe),
        .periph_in(periph_in), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_pullup(pin_pullup));
    pin_board board_u (.mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val),
        .pin_in(pin_in));
// ****************
// bus tasks, entered and left at a falling edge
// ****************
    task automatic step(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1;
        step(1);
        sfr_wr = 0;
        step(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic m, output logic [7:0] d);
        sfr_addr = a;
        sfr_rmw = m;
        sfr_rd = 1;
        step(1);
        sfr_rd = 0;
        step(1);
        d = sfr_rdata;
    endtask
    task automatic brd(input logic [7:0] a, input logic m, output logic v);
        sfr_bit_addr = a;
        sfr_rmw = m;
        sfr_bit_rd = 1;
        step(1);
        sfr_bit_rd = 0;
        step(1);
        v = sfr_bit_rdata;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        if (errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
// ****************
// scenarios
// ****************
    task automatic t_reset;
        logic [7:0] d;
        logic [7:0] a [8] = '{8'hE1, 8'hE2, 8'hF3, 8'hA4, 8'hD4, 8'hF1, 8'hF2, 8'h81};
        logic [7:0] e [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00};
        for (int i = 0; i < 8; i++) begin
            rd(a[i], 0, d);
            chk(d, e[i]);
        end
        chk(pin_oe, 16'h0000);
        chk(pin_pullup, 16'hFFFF);
    endtask
    task automatic t_gpio;
        logic [7:0] d;
        logic       v;
        wr(8'hE2, 8'h40);
        wr(8'h80, 8'h5A);
        wr(8'hA4, 8'h0F);
        sfr_bit_addr = 8'h93;
        sfr_bit_wr = 1;
        step(1);
        sfr_bit_wr = 0;
        step(4);
        chk(pin_out, 16'hF75A);
        chk(pin_oe, 16'h08AF);
        chk(pin_pullup, 16'hF750);
        ext_en = 16'h0040;
        step(6);
        rd(8'h80, 0, d);
        chk(d, 8'h1A);
        rd(8'h80, 1, d);
        chk(d, 8'h5A);
        brd(8'h93, 1, v);
        chk(v, 0);
        brd(8'h86, 0, v);
        chk(v, 0);
        ext_en = 0;
        wr(8'hF1, 8'hF7);
        step(6);
        rd(8'h80, 0, d);
        chk({d[3], pin_oe[3], pin_pullup[3]}, 0);
        wr(8'hF1, 8'hFF);
    endtask
    task automatic t_route;
        logic [7:0] d;
        wr(8'hD4, 8'h01);
        wr(8'hA4, 8'hFF);
        wr(8'h80, 8'hFF);
        periph_oe = 23'h0000C1;
        wr(8'hE1, 8'h05);
        step(4);
        chk(pin_oe[4:0], 5'b11001);
        periph_out[0] = 0;
        periph_out[6] = 0;
        step(4);
        chk(pin_out[4:0], 5'b01101);
        chk(pin_oe[4:0], 5'b11011);
        ext_en = 16'h0020;
        step(6);
        chk(periph_in[1], 0);
        ext_en = 0;
        wr(8'hE1, 8'h01);
        periph_oe = 23'h206000;
        periph_out = 23'h1FFFFF & ~23'h006000;
        wr(8'hE2, 8'h42);
        step(4);
        chk(pin_out[2:1], 2'b00);
        wr(8'hE2, 8'h46);
        step(4);
        chk(pin_out[2:1], 2'b11);
        wr(8'hF3, 8'h01);
        periph_oe = 23'h201000;
        wr(8'hE1, 8'h09);
        wr(8'hE2, 8'h40);
        step(4);
        chk(pin_out[2:1], 2'b01);
        rd(8'hF3, 0, d);
        chk(d, 8'h01);
        rd(8'hE2, 0, d);
        chk(d, 8'h40);
        wr(8'hE2, 8'hC0);
        step(4);
        chk(pin_pullup, 16'h0000);
        wr(8'hE2, 8'h00);
        step(4);
        chk(pin_oe, 16'h0000);
    endtask
    initial begin
        #400000;
        errors++;
        report_and_stop();
    end
    initial begin
        step(12);
        rst_b = 1;
        step(3);
        t_reset();
        t_gpio();
        t_route();
        report_and_stop();
    end
endmodule
`default_nettype wire
